// ==== tcw_copy_seq.v ====
// Word sequencer that steps through the staging cache during a copy
`default_nettype none
module tcw_copy_seq (
   input wire pclk,
   input wire presetn,
   input wire start,
   input wire [4:0] last_index,
   output wire step,
   output wire [4:0] index,
   output wire done
);
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_RUN = 2'b10;
   reg [1:0] state_reg;
   reg [4:0] index_reg;
   reg [4:0] last_reg;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         index_reg <= 5'h00;
         last_reg <= 5'h00;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               index_reg <= 5'h00;
               if (start) begin
                  last_reg <= last_index;
                  state_reg <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (index_reg == last_reg) begin
                  state_reg <= ST_IDLE;
                  index_reg <= 5'h00;
               end else begin
                  index_reg <= index_reg + 5'h01;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
               index_reg <= 5'h00;
            end
         endcase
      end
   end

   assign step = state_reg[1];
   assign index = index_reg;
   assign done = state_reg[1] && (index_reg == last_reg);
endmodule // tcw_copy_seq
`default_nettype wire

// ==== tcw_defines.vh ====
// Constants for the matcher rule staging-cache writer
`ifndef TCW_DEFINES_VH
`define TCW_DEFINES_VH
// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define TCW_OFS_CTRL 12'h000
`define TCW_OFS_CFG 12'h004
`define TCW_OFS_STAT 12'h008
`define TCW_OFS_CNT 12'h00c
`define TCW_OFS_KEY0 12'h010
`define TCW_OFS_KEY1 12'h014
`define TCW_OFS_CARE0 12'h018
`define TCW_OFS_CARE1 12'h01c
`define TCW_RES_BASE_HI 6'h01
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define TCW_CTRL_WIPE 0
`define TCW_CTRL_GO 2
`define TCW_CTRL_ADDR_LSB 3
`define TCW_ADDR_W 14
`define TCW_CFG_MAPPED 0
`define TCW_CFG_EGRESS 1
`define TCW_STAT_RANGE_ERR 0
// ---------------------------------------------------------------
// Staging widths
// ---------------------------------------------------------------
`define TCW_KEY_HI_CLS 20
`define TCW_KEY_HI_EGR 19
`define TCW_RES_WORDS 16
`define TCW_RES_TOP_CLS 14
`define TCW_RES_TOP_EGR 9
`define TCW_LAST_WORD_CLS 5'h08
`define TCW_LAST_WORD_EGR 5'h14
`define TCW_RES_FIRST_WORD 5'h05
// ---------------------------------------------------------------
// Address ranges
// ---------------------------------------------------------------
`define TCW_EGR_ADDR_MAX 14'h0fff
`define TCW_CLS_ADDR_LO 14'h0c00
`define TCW_CLS_ADDR_HI 14'h2400
// ---------------------------------------------------------------
// Reset and wipe values
// ---------------------------------------------------------------
`define TCW_WIPE_WORD 32'h00000000
`endif

// ==== tcw_rule_cache_writer.v ====
// APB staging cache and copy engine for matcher rule writes
//
// Rules from the document
// RL1 - Software sizes rule by larger part
// RL2 - Software aligns start to both sizes
// RL3 - Software tracks free addresses, wipes to delete
// RL4 - Key value and care hold 52 bits
// RL5 - Result staging holds 110 bits per address
// RL6 - Software programs unused key bits match-zero
// RL7 - Software writes unused result bits zero
// RL8 - Software writes highest offset first
// RL9 - Software waits for go clear first
// RL10 - Wipe write clears key, care, result, counter
// RL11 - Go write copies cache to target address
// RL12 - Go clears only after copy finishes
// RL13 - Wiped key reads match-off
// RL14 - Software puts key type-group in low bits
// RL15 - Software writes type-group care bits zero
// RL16 - Software puts result type-group low bits
// RL17 - Egress matcher owns 0-4095, no sharing
// RL18 - Egress rule: 51-bit key, 489-bit result
// RL19 - Mapped classification lookup owns 3072-9216
// RL20 - Staging stays stable while go is set
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`default_nettype none
`include "tcw_defines.vh"
module tcw_rule_cache_writer (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg mem_we,
   output reg mem_egress,
   output reg [13:0] mem_addr,
   output reg [4:0] mem_word,
   output reg [31:0] mem_wdata
);
   reg go_reg;
   reg start_reg;
   reg done_d_reg;
   reg [13:0] target_reg;
   reg mapped_reg;
   reg egress_reg;
   reg range_err_reg;
   reg counter_reg;
   reg [31:0] key0_reg;
   reg [`TCW_KEY_HI_CLS-1:0] key1_reg;
   reg [31:0] care0_reg;
   reg [`TCW_KEY_HI_CLS-1:0] care1_reg;
   reg [31:0] result_reg [0:`TCW_RES_WORDS-1];
   reg [31:0] rd_mux;
   reg [31:0] word_mux;
   reg addr_hit;
   wire access;
   wire wr_ok;
   wire res_hit;
   wire [3:0] res_idx;
   wire staging_hit;
   wire [13:0] go_addr;
   wire range_ok;
   wire go_req;
   wire wipe_req;
   wire seq_step;
   wire [4:0] seq_index;
   wire seq_done;
   wire [4:0] res_sel;
   integer i;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   assign access = psel && penable && !pready;
   assign res_hit = (paddr[11:6] == `TCW_RES_BASE_HI);
   assign res_idx = paddr[5:2];
   assign staging_hit = res_hit || (paddr == `TCW_OFS_CNT) ||
      (paddr == `TCW_OFS_KEY0) || (paddr == `TCW_OFS_KEY1) ||
      (paddr == `TCW_OFS_CARE0) || (paddr == `TCW_OFS_CARE1);
   // Staging writes during a copy are refused [RL20]
   assign wr_ok = access && pwrite && addr_hit &&
      !(staging_hit && go_reg);
   assign go_addr = pwdata[`TCW_CTRL_ADDR_LSB+`TCW_ADDR_W-1:
      `TCW_CTRL_ADDR_LSB];
   // Egress owns its full range, mapped classification its mapped range, unmapped classification any address
   assign range_ok = egress_reg ? (go_addr <= `TCW_EGR_ADDR_MAX) :
      (!mapped_reg || ((go_addr >= `TCW_CLS_ADDR_LO) &&
      (go_addr <= `TCW_CLS_ADDR_HI))); // [RL17] [RL19]
   assign wipe_req = wr_ok && (paddr == `TCW_OFS_CTRL) && !go_reg &&
      pwdata[`TCW_CTRL_WIPE];
   assign go_req = wr_ok && (paddr == `TCW_OFS_CTRL) && !go_reg &&
      !pwdata[`TCW_CTRL_WIPE] && pwdata[`TCW_CTRL_GO];

   always @* begin
      addr_hit = 1'b1;
      rd_mux = 32'h00000000;
      if (res_hit) begin
         rd_mux = result_reg[res_idx];
      end else begin
         case (paddr)
            `TCW_OFS_CTRL: rd_mux = {15'h0000, target_reg, go_reg, 2'h0};
            `TCW_OFS_CFG: rd_mux = {30'h00000000, egress_reg, mapped_reg};
            `TCW_OFS_STAT: rd_mux = {31'h00000000, range_err_reg};
            `TCW_OFS_CNT: rd_mux = {31'h00000000, counter_reg};
            `TCW_OFS_KEY0: rd_mux = key0_reg;
            `TCW_OFS_KEY1: rd_mux = {12'h000, key1_reg};
            `TCW_OFS_CARE0: rd_mux = care0_reg;
            `TCW_OFS_CARE1: rd_mux = {12'h000, care1_reg};
            default: addr_hit = 1'b0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // APB answer, one wait state
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= access;
         pslverr <= access && !(addr_hit &&
            !(pwrite && staging_hit && go_reg)); // [RL9]
         prdata <= (access && !pwrite && addr_hit) ? rd_mux :
            32'h00000000;
      end
   end

   // ------------------------------------------------------------
   // Control and status
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         go_reg <= 1'b0;
         start_reg <= 1'b0;
         done_d_reg <= 1'b0;
         target_reg <= 14'h0000;
         mapped_reg <= 1'b0;
         egress_reg <= 1'b0;
         range_err_reg <= 1'b0;
      end else begin
         start_reg <= go_req && range_ok;
         done_d_reg <= seq_done;
         if (go_req && range_ok) begin
            go_reg <= 1'b1; // [RL11]
            target_reg <= go_addr;
         end else if (done_d_reg) begin
            go_reg <= 1'b0; // [RL12]
         end
         if (wr_ok && (paddr == `TCW_OFS_CFG) && !go_reg) begin
            mapped_reg <= pwdata[`TCW_CFG_MAPPED];
            egress_reg <= pwdata[`TCW_CFG_EGRESS];
         end
         // A new refusal wins over a clear in the same cycle
         if (go_req && !range_ok) begin
            range_err_reg <= 1'b1;
         end else if (wr_ok && (paddr == `TCW_OFS_STAT) &&
            pwdata[`TCW_STAT_RANGE_ERR]) begin
            range_err_reg <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Staging cache
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_reg <= 1'b0;
         key0_reg <= `TCW_WIPE_WORD;
         key1_reg <= {`TCW_KEY_HI_CLS{1'b0}};
         care0_reg <= `TCW_WIPE_WORD;
         care1_reg <= {`TCW_KEY_HI_CLS{1'b0}};
         for (i = 0; i < `TCW_RES_WORDS; i = i + 1) begin
            result_reg[i] <= `TCW_WIPE_WORD;
         end
      end else if (wipe_req) begin
         // Wiped key and care leave the address match-off
         counter_reg <= 1'b0; // [RL10]
         key0_reg <= `TCW_WIPE_WORD; // [RL13]
         key1_reg <= {`TCW_KEY_HI_CLS{1'b0}};
         care0_reg <= `TCW_WIPE_WORD;
         care1_reg <= {`TCW_KEY_HI_CLS{1'b0}};
         for (i = 0; i < `TCW_RES_WORDS; i = i + 1) begin
            result_reg[i] <= `TCW_WIPE_WORD; // [RL10]
         end
      end else if (wr_ok) begin
         if (res_hit) begin
            result_reg[res_idx] <= pwdata;
         end
         case (paddr)
            `TCW_OFS_CNT: counter_reg <= pwdata[0];
            `TCW_OFS_KEY0: key0_reg <= pwdata;
            `TCW_OFS_KEY1: key1_reg <= pwdata[`TCW_KEY_HI_CLS-1:0]; // [RL4]
            `TCW_OFS_CARE0: care0_reg <= pwdata;
            `TCW_OFS_CARE1: care1_reg <= pwdata[`TCW_KEY_HI_CLS-1:0];
            default: counter_reg <= counter_reg;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Copy word selection, trimmed to the matcher's widths
   // ------------------------------------------------------------
   assign res_sel = seq_index - `TCW_RES_FIRST_WORD;

   always @* begin
      word_mux = 32'h00000000;
      case (seq_index)
         5'h00: word_mux = key0_reg;
         5'h01: word_mux = egress_reg ?
            {13'h0000, key1_reg[`TCW_KEY_HI_EGR-1:0]} :
            {12'h000, key1_reg}; // [RL4] [RL18]
         5'h02: word_mux = care0_reg;
         5'h03: word_mux = egress_reg ?
            {13'h0000, care1_reg[`TCW_KEY_HI_EGR-1:0]} :
            {12'h000, care1_reg};
         5'h04: word_mux = {31'h00000000, counter_reg};
         default: begin
            word_mux = result_reg[res_sel[3:0]];
            if (!egress_reg && (res_sel == 5'h03)) begin
               word_mux = {18'h00000,
                  result_reg[3][`TCW_RES_TOP_CLS-1:0]}; // [RL5]
            end
            if (egress_reg && (res_sel == 5'h0f)) begin
               word_mux = {23'h000000,
                  result_reg[15][`TCW_RES_TOP_EGR-1:0]}; // [RL18]
            end
         end
      endcase
   end

   tcw_copy_seq u_seq (
      .pclk(pclk),
      .presetn(presetn),
      .start(start_reg),
      .last_index(egress_reg ? `TCW_LAST_WORD_EGR : `TCW_LAST_WORD_CLS),
      .step(seq_step),
      .index(seq_index),
      .done(seq_done)
   );

   // ------------------------------------------------------------
   // Matcher write port
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_we <= 1'b0;
         mem_egress <= 1'b0;
         mem_addr <= 14'h0000;
         mem_word <= 5'h00;
         mem_wdata <= 32'h00000000;
      end else begin
         mem_we <= seq_step; // [RL11]
         mem_egress <= egress_reg;
         mem_addr <= target_reg;
         mem_word <= seq_index;
         mem_wdata <= seq_step ? word_mux : 32'h00000000;
      end
   end
endmodule // tcw_rule_cache_writer
`default_nettype wire

// ==== tcw_rule_cache_writer_bench.sv ====
// Self-checking testbench of the rule staging-cache writer
`default_nettype none
`include "tcw_defines.vh"
module tcw_rule_cache_writer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic mem_we, mem_egress, qe;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, mem_wdata, r, seed;
   logic [13:0] mem_addr, qa, tgt;
   logic [4:0] mem_word;
   logic [31:0] st [0:20];
   logic [4:0] qw [$];
   logic [31:0] qd [$];
   logic [1:0] cfg_t [0:7] = '{1, 1, 1, 1, 2, 2, 2, 0};
   logic [13:0] adr_t [0:7] = '{4482, 3071, 9216, 9217, 1215, 4095, 4096,
      100};
   int errors, n_checks;
   tcw_rule_cache_writer u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mem_we(mem_we), .mem_egress(mem_egress),
      .mem_addr(mem_addr), .mem_word(mem_word), .mem_wdata(mem_wdata));
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [11:0] ofs(input int i);
      if (i < 4) return 12'h010 + 12'(4 * i);
      if (i == 4) return `TCW_OFS_CNT;
      return 12'h040 + 12'(4 * (i - 5));
   endfunction
   function automatic logic [31:0] cmask(input int i, input logic eg);
      if (i == 1 || i == 3) return eg ? 32'h0007ffff : 32'h000fffff;
      if (i == 4) return 32'h00000001;
      if (i == 8 && !eg) return 32'h00003fff;
      if (i == 20) return 32'h000001ff;
      return 32'hffffffff;
   endfunction
   function automatic logic [31:0] tgrp(input int i, input logic [31:0] v);
      case (i)
         0: return {v[31:2], 2'b10};
         1: return v & 32'hfff7ffff;
         2: return {v[31:2], 2'b00};
         3: return v | 32'h00080000;
         5: return {v[31:3], 3'b100};
         8: return v & 32'hffffc0ff;
         default: return v;
      endcase
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      n_checks++;
      if (g !== x) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) errors++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // ---------------------------------------------------------------
   // One rule write through the cache
   // ---------------------------------------------------------------
   task automatic go_case(input logic [1:0] cfg, input logic [13:0] a);
      logic ok, eg;
      int n;
      eg = cfg[1];
      ok = eg ? a <= 14'd4095 : !cfg[0] || (a >= 14'd3072 && a <= 14'd9216);
      apb(1'b1, `TCW_OFS_CFG, {30'h0, cfg});
      apb(1'b1, `TCW_OFS_CTRL, 32'h1);
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, ofs(i), 32'h0);
         chk(r, 32'h0);
      end
      for (int i = 20; i >= 0; i--) begin
         st[i] = rnd();
         if (!eg) st[i] = tgrp(i, st[i]);
         apb(1'b1, ofs(i), st[i]);
      end
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, ofs(i), 32'h0);
         chk(r, st[i] & cmask(i, 1'b0));
      end
      qw.delete();
      qd.delete();
      if (ok) tgt = a;
      apb(1'b1, `TCW_OFS_CTRL, 32'h4 | (32'(a) << 3));
      apb(1'b0, `TCW_OFS_CTRL, 32'h0);
      chk(r, (32'(tgt) << 3) | (ok ? 32'h4 : 32'h0));
      apb(1'b1, `TCW_OFS_KEY0, 32'h5a5a5a5a);
      chk({31'h0, e}, {31'h0, ok});
      if (!ok) st[0] = 32'h5a5a5a5a;
      n = 0;
      do begin
         apb(1'b0, `TCW_OFS_CTRL, 32'h0);
         n++;
      end while (r[2] !== 1'b0 && n < 40);
      chk(r, 32'(tgt) << 3);
      apb(1'b0, `TCW_OFS_STAT, 32'h0);
      chk(r, {31'h0, !ok});
      apb(1'b1, `TCW_OFS_STAT, 32'h1);
      chk(32'(qw.size()), ok ? (eg ? 32'd21 : 32'd9) : 32'd0);
      foreach (qw[i]) begin
         chk({27'h0, qw[i]}, 32'(i));
         chk(qd[i], st[i] & cmask(i, eg));
      end
      if (ok) chk({17'h0, qe, qa}, {17'h0, eg, a});
   endtask
   // ---------------------------------------------------------------
   // Clock, capture, watchdog and main sequence
   // ---------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (mem_we === 1'b1) begin
         qw.push_back(mem_word);
         qd.push_back(mem_wdata);
         qa = mem_addr;
         qe = mem_egress;
      end
   end
   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      stop_test();
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      seed = 32'h3bd38d02;
      errors = 0;
      n_checks = 0;
      tgt = 14'h0000;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0);
         chk(r, 32'h0);
      end
      apb(1'b0, 12'h030, 32'h0);
      chk({r[30:0], e}, 32'h1);
      for (int c = 0; c < 8; c++) go_case(cfg_t[c], adr_t[c]);
      stop_test();
   end
endmodule // tcw_rule_cache_writer_bench
`default_nettype wire

// ==== tcw_rule_cache_writer_sva.sv ====
// Port checker for the rule staging-cache writer
`default_nettype none
module tcw_rule_cache_writer_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic mem_we,
   input wire logic mem_egress,
   input wire logic [13:0] mem_addr,
   input wire logic [4:0] mem_word,
   input wire logic [31:0] mem_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] run_q;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ---------------------------------------------------------------
   // Copy run length
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         run_q <= 5'h00;
      else
         run_q <= mem_we ? run_q + 5'h01 : 5'h00;
   end
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   ans_one_a: assert property (
      psel && penable && !pready |=> pready ##1 !pready)
      else $error("apb answer not one cycle");
   run_len_a: assert property (
      $fell(mem_we) |-> run_q == 5'h09 || run_q == 5'h15)
      else $error("copy run length wrong");
   word_first_a: assert property (
      $rose(mem_we) |-> mem_word == 5'h00)
      else $error("copy does not start at word 0");
   word_step_a: assert property (
      mem_we && $past(mem_we) |-> mem_word == $past(mem_word) + 5'h01)
      else $error("copy word index skipped");
   tgt_hold_a: assert property (
      mem_we && $past(mem_we) |-> $stable(mem_addr) && $stable(mem_egress))
      else $error("copy target moved");
   idle_zero_a: assert property (
      !mem_we |-> mem_wdata == 32'h00000000)
      else $error("copy data not zero when idle");
   key_trim_a: assert property (
      mem_we && mem_word[0] && mem_word <= 5'h03 |->
      mem_wdata[31:20] == 12'h000 && !(mem_egress && mem_wdata[19]))
      else $error("key high word not trimmed");
   res_trim_a: assert property (
      mem_we && !mem_egress && mem_word == 5'h08 |-> mem_wdata[31:14] == 0)
      else $error("result last word not trimmed");
   egr_trim_a: assert property (
      mem_we && mem_word == 5'h14 |-> mem_egress && mem_wdata[31:9] == 0)
      else $error("egress last word not trimmed");
   egr_range_a: assert property (
      mem_we && mem_egress |-> mem_addr <= 14'h0fff)
      else $error("egress copy out of range");
   cover property (mem_we && mem_egress && mem_word == 5'h14);
   cover property (mem_we && !mem_egress && mem_word == 5'h08);
   cover property (pready && pslverr);
endmodule // tcw_rule_cache_writer_chk
bind tcw_rule_cache_writer tcw_rule_cache_writer_chk u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .mem_we(mem_we),
   .mem_egress(mem_egress), .mem_addr(mem_addr), .mem_word(mem_word),
   .mem_wdata(mem_wdata));
`default_nettype wire
